//--- lpd_pkg.sv
// Package: register map, field layout and timing constants of the LED PWM driver
package lpd_pkg;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] LPD_OFS_SHUTDOWN  = 8'h00; // Soft shutdown register
    localparam logic [7:0] LPD_OFS_DUTY_LO   = 8'h01; // Channel 1 duty
    localparam logic [7:0] LPD_OFS_DUTY_HI   = 8'h12; // Channel 18 duty
    localparam logic [7:0] LPD_OFS_APPLY     = 8'h13; // apply_pending_values
    localparam logic [7:0] LPD_OFS_SCALE_LO  = 8'h14; // Channel 1 current scale
    localparam logic [7:0] LPD_OFS_SCALE_HI  = 8'h25; // Channel 18 current scale
    localparam logic [7:0] LPD_OFS_GLOBAL    = 8'h26; // global_output_control
    localparam logic [7:0] LPD_OFS_FREQ      = 8'h27; // pwm_frequency_select
    localparam logic [7:0] LPD_OFS_RESTORE   = 8'h2f; // register_defaults_restore

    // ==========================================================
    // Command values and reset values
    // ==========================================================
    localparam logic [7:0] LPD_CMD_TRIGGER   = 8'h00; // Value that fires apply or restore
    localparam logic [7:0] LPD_DUTY_RST      = 8'h00; // Duty reset value
    localparam logic [5:0] LPD_SCALE_RST     = 6'h00; // Scale reset value (off)
    localparam logic       LPD_BIT_RST       = 1'b0;  // Single-bit control reset value

    // ==========================================================
    // Current scale codes
    // ==========================================================
    localparam logic [5:0] LPD_SCALE_FULL    = 6'h10; // 12/12
    localparam logic [5:0] LPD_SCALE_11      = 6'h11; // 11/12
    localparam logic [5:0] LPD_SCALE_9       = 6'h12; // 9/12
    localparam logic [5:0] LPD_SCALE_7       = 6'h13; // 7/12
    localparam int         LPD_SCALE_ON_BIT  = 4;     // Code bit that marks a lit channel

    // ==========================================================
    // Timing: one PWM period is 256 counter ticks
    // ==========================================================
    localparam int LPD_CLK_HZ      = 100_000_000; // System clock rate
    localparam int LPD_FAST_HZ     = 23_000;      // Default PWM frequency
    localparam int LPD_SLOW_MILLIHZ = 3_450_000;  // Slow PWM frequency, in mHz
    localparam int LPD_STEPS       = 256;         // Ticks per PWM period
    // Divider rounds down: period at most the target, so the rate figure is a lower bound
    localparam int LPD_FAST_DIV    = LPD_CLK_HZ / (LPD_FAST_HZ * LPD_STEPS);
    localparam int LPD_SLOW_DIV    =
        int'((64'(LPD_CLK_HZ) * 1000) / (64'(LPD_SLOW_MILLIHZ) * LPD_STEPS));

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic       wr;   // One-cycle write strobe
        logic [7:0] addr; // Register offset
        logic [7:0] data; // Write data
    } lpd_wr_t;

    typedef struct packed {
        logic       soft_run;   // 1 = normal, 0 = software shutdown
        logic       all_off;    // 1 = force every output off
        logic       slow_freq;  // 1 = slow PWM rate
    } lpd_ctrl_t;

endpackage

//--- lpd_led_pwm.sv
// Module: 18-channel LED PWM driver with shadowed duty/scale registers
// Contract
// - Soft shutdown bit clear means shutdown
// - Eighteen 8-bit duty registers, reset zero
// - Current equals max times duty over 256
// - Duty and scale writes go to holding
// - Zero write to 13h copies holding to active
// - Scale codes 10h-13h lit, 00xxxx dark
// - Duty 01h-12h, scale 14h-25h, channel ascending
// - Global bit D0 set forces outputs off
// - Frequency bit D0 picks 23k or 3.45k
// - Zero write to 2Fh restores all defaults
// - Power-up loads defaults, outputs dark
// - Software shutdown switches all outputs off
// - Hardware shutdown input low forces off
// - Registers kept during either shutdown
// - All channels share one PWM time base
`timescale 1ns/1ps

module lpd_led_pwm
    import lpd_pkg::*;
#(
    parameter int NUM_CH   = 18,            // Channel count
    parameter int FAST_DIV = LPD_FAST_DIV,  // Clocks per tick at fast rate
    parameter int SLOW_DIV = LPD_SLOW_DIV   // Clocks per tick at slow rate
) (
    // Clock and reset
    input  wire logic              MCLK_IN,
    input  wire logic              SRST_IN,
    // Register write port
    input  wire lpd_wr_t           REG_WR_IN,
    // Hardware shutdown, active low
    input  wire logic              HW_SHUTDOWN_N_IN,
    // LED sinks and current scale per channel
    output logic [NUM_CH-1:0]      LED_CHANNEL_OUTPUTS_OUT,
    output logic [NUM_CH*6-1:0]    CURRENT_SCALE_FIELD_OUT,
    // Status
    output logic [7:0]             PERIOD_COUNT_OUT
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    initial begin
        if (NUM_CH < 1 || NUM_CH > 18) begin
            $error("NUM_CH must lie in 1..18");
        end
        if (FAST_DIV < 1 || SLOW_DIV < 1 || FAST_DIV > 65535 || SLOW_DIV > 65535) begin
            $error("Dividers must lie in 1..65535");
        end
    end

    localparam logic [15:0] FAST_LAST = 16'(FAST_DIV - 1); // Last prescale count fast
    localparam logic [15:0] SLOW_LAST = 16'(SLOW_DIV - 1); // Last prescale count slow

    // ==========================================================
    // Register state
    // ==========================================================
    logic [7:0] duty_hold_r   [NUM_CH]; // Holding duty
    logic [7:0] duty_hold_nxt [NUM_CH];
    logic [7:0] duty_act_r    [NUM_CH]; // Active duty
    logic [7:0] duty_act_nxt  [NUM_CH];
    logic [5:0] scale_hold_r  [NUM_CH]; // Holding scale
    logic [5:0] scale_hold_nxt[NUM_CH];
    logic [5:0] scale_act_r   [NUM_CH]; // Active scale
    logic [5:0] scale_act_nxt [NUM_CH];
    lpd_ctrl_t  ctrl_r;                 // Global control bits
    lpd_ctrl_t  ctrl_nxt;

    // Decoded strobes
    logic wr_apply;   // Update trigger
    logic wr_restore; // Defaults restore

    assign wr_apply   = REG_WR_IN.wr && REG_WR_IN.addr == LPD_OFS_APPLY
                        && REG_WR_IN.data == LPD_CMD_TRIGGER;
    assign wr_restore = REG_WR_IN.wr && REG_WR_IN.addr == LPD_OFS_RESTORE
                        && REG_WR_IN.data == LPD_CMD_TRIGGER;

    // Global control next state, decoded by if chain
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_restore) begin
            ctrl_nxt = '{LPD_BIT_RST, LPD_BIT_RST, LPD_BIT_RST};
        end else if (REG_WR_IN.wr && REG_WR_IN.addr == LPD_OFS_SHUTDOWN) begin
            ctrl_nxt.soft_run = REG_WR_IN.data[0];
        end else if (REG_WR_IN.wr && REG_WR_IN.addr == LPD_OFS_GLOBAL) begin
            ctrl_nxt.all_off = REG_WR_IN.data[0];
        end else if (REG_WR_IN.wr && REG_WR_IN.addr == LPD_OFS_FREQ) begin
            ctrl_nxt.slow_freq = REG_WR_IN.data[0];
        end
    end

    // Per-channel holding and active registers
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            localparam logic [7:0] DUTY_OFS  = 8'(LPD_OFS_DUTY_LO + g);
            localparam logic [7:0] SCALE_OFS = 8'(LPD_OFS_SCALE_LO + g);

            // Writes land in holding; update copies all channels at once
            always_comb begin
                duty_hold_nxt[g]  = duty_hold_r[g];
                scale_hold_nxt[g] = scale_hold_r[g];
                duty_act_nxt[g]   = duty_act_r[g];
                scale_act_nxt[g]  = scale_act_r[g];
                if (wr_restore) begin
                    duty_hold_nxt[g]  = LPD_DUTY_RST;
                    scale_hold_nxt[g] = LPD_SCALE_RST;
                    duty_act_nxt[g]   = LPD_DUTY_RST;
                    scale_act_nxt[g]  = LPD_SCALE_RST;
                end else if (wr_apply) begin
                    duty_act_nxt[g]  = duty_hold_r[g];
                    scale_act_nxt[g] = scale_hold_r[g];
                end else if (REG_WR_IN.wr && REG_WR_IN.addr == DUTY_OFS) begin
                    duty_hold_nxt[g] = REG_WR_IN.data;
                end else if (REG_WR_IN.wr && REG_WR_IN.addr == SCALE_OFS) begin
                    scale_hold_nxt[g] = REG_WR_IN.data[5:0];
                end
            end

            // Registers only; shutdown never touches them
            always_ff @(posedge MCLK_IN) begin
                if (SRST_IN) begin
                    duty_hold_r[g]  <= LPD_DUTY_RST;
                    scale_hold_r[g] <= LPD_SCALE_RST;
                    duty_act_r[g]   <= LPD_DUTY_RST;
                    scale_act_r[g]  <= LPD_SCALE_RST;
                end else begin
                    duty_hold_r[g]  <= duty_hold_nxt[g];
                    scale_hold_r[g] <= scale_hold_nxt[g];
                    duty_act_r[g]   <= duty_act_nxt[g];
                    scale_act_r[g]  <= scale_act_nxt[g];
                end
            end
        end
    endgenerate

    // Control register
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            ctrl_r <= '{LPD_BIT_RST, LPD_BIT_RST, LPD_BIT_RST};
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ==========================================================
    // Shared time base
    // ==========================================================
    logic [15:0] pre_r;   // Prescaler
    logic [15:0] pre_nxt;
    logic [7:0]  cnt_r;   // Period counter, one for all channels
    logic [7:0]  cnt_nxt;
    logic        tick;    // One-cycle enable per step

    // Prescaler picks the rate; counter wraps every 256 ticks
    always_comb begin
        tick    = pre_r >= (ctrl_r.slow_freq ? SLOW_LAST : FAST_LAST);
        pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
        cnt_nxt = tick ? cnt_r + 8'h01 : cnt_r;
    end

    // Time base registers
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            pre_r <= 16'h0000;
            cnt_r <= 8'h00;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================================
    // Output stage
    // ==========================================================
    logic [NUM_CH-1:0]   led_nxt;   // Next output state
    logic [NUM_CH-1:0]   led_r;
    logic [NUM_CH*6-1:0] scale_nxt; // Next scale bus
    logic [NUM_CH*6-1:0] scale_r;
    logic                run;       // No shutdown of any kind and global off bit clear

    // Duty fraction of 256 gives average current; scale carried out
    always_comb begin
        run = ctrl_r.soft_run && !ctrl_r.all_off && HW_SHUTDOWN_N_IN;
        for (int i = 0; i < NUM_CH; i++) begin
            led_nxt[i] = run && scale_act_r[i][LPD_SCALE_ON_BIT]
                         && (cnt_r < duty_act_r[i]);
            scale_nxt[i*6 +: 6] = run ? scale_act_r[i] : LPD_SCALE_RST;
        end
    end

    // Registered outputs
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            led_r   <= '0;
            scale_r <= '0;
        end else begin
            led_r   <= led_nxt;
            scale_r <= scale_nxt;
        end
    end

    assign LED_CHANNEL_OUTPUTS_OUT = led_r;
    assign CURRENT_SCALE_FIELD_OUT = scale_r;
    assign PERIOD_COUNT_OUT        = cnt_r;

endmodule

//--- lpd_led_pwm_checker.sv
// Checker: port-level properties of the LED PWM driver
`timescale 1ns/1ps

module lpd_led_pwm_checker
    import lpd_pkg::*;
#(
    parameter int NUM_CH   = 18, // Channel count
    parameter int FAST_DIV = 1,  // Clocks per fast tick
    parameter int SLOW_DIV = 2   // Clocks per slow tick
) (
    // Clock and reset
    input wire logic                MCLK_IN,
    input wire logic                SRST_IN,
    // Inputs
    input wire lpd_wr_t             REG_WR_IN,
    input wire logic                HW_SHUTDOWN_N_IN,
    // Outputs
    input wire logic [NUM_CH-1:0]   LED_CHANNEL_OUTPUTS_OUT,
    input wire logic [NUM_CH*6-1:0] CURRENT_SCALE_FIELD_OUT,
    input wire logic [7:0]          PERIOD_COUNT_OUT
);
    // ==========================================================
    // Helpers
    // ==========================================================
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SRST_IN);
    logic [7:0] prev_r, prev_nxt;   // Counter one cycle ago
    logic [7:0] still_r, still_nxt; // Cycles without a tick
    // Stall length; assumes SLOW_DIV is the longer tick
    always_comb begin
        prev_nxt  = SRST_IN ? 8'h00 : PERIOD_COUNT_OUT;
        still_nxt = (SRST_IN || PERIOD_COUNT_OUT != prev_r) ? 8'h00 : still_r + 8'h01;
    end
    always_ff @(posedge MCLK_IN) begin
        prev_r  <= prev_nxt;
        still_r <= still_nxt;
    end
    sequence s_wr(logic [7:0] a, logic [7:0] d);
        REG_WR_IN.wr && REG_WR_IN.addr == a && REG_WR_IN.data == d;
    endsequence
    sequence s_dark;
        LED_CHANNEL_OUTPUTS_OUT == '0 && CURRENT_SCALE_FIELD_OUT == '0;
    endsequence
    // ==========================================================
    // Properties
    // ==========================================================
    a_reset_dark: assert property ($fell(SRST_IN) |-> s_dark)
        else $error("outputs not dark after reset");
    a_hw_dark: assert property (!HW_SHUTDOWN_N_IN |=> s_dark)
        else $error("outputs lit in hardware shutdown");
    a_soft_off: assert property (s_wr(LPD_OFS_SHUTDOWN, 8'h00) |=> ##1 s_dark)
        else $error("outputs lit in software shutdown");
    a_global_off: assert property (s_wr(LPD_OFS_GLOBAL, 8'h01) |=> ##1 LED_CHANNEL_OUTPUTS_OUT == '0)
        else $error("outputs lit while globally disabled");
    a_restore_dark: assert property (s_wr(LPD_OFS_RESTORE, 8'h00) |=> ##1 s_dark)
        else $error("outputs lit after restore");
    a_count_step: assert property (!$stable(PERIOD_COUNT_OUT) |->
        PERIOD_COUNT_OUT == $past(PERIOD_COUNT_OUT) + 8'h01)
        else $error("period counter skipped");
    a_count_runs: assert property (still_r <= SLOW_DIV)
        else $error("period counter stalled");
    a_scale_gate: assert property ((CURRENT_SCALE_FIELD_OUT[4] == 1'b0) [*3]
        |-> !LED_CHANNEL_OUTPUTS_OUT[0])
        else $error("channel lit with dark scale code");
endmodule

bind lpd_led_pwm lpd_led_pwm_checker #(.NUM_CH(NUM_CH), .FAST_DIV(FAST_DIV),
    .SLOW_DIV(SLOW_DIV)) u_chk (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN),
    .REG_WR_IN(REG_WR_IN), .HW_SHUTDOWN_N_IN(HW_SHUTDOWN_N_IN),
    .LED_CHANNEL_OUTPUTS_OUT(LED_CHANNEL_OUTPUTS_OUT),
    .CURRENT_SCALE_FIELD_OUT(CURRENT_SCALE_FIELD_OUT), .PERIOD_COUNT_OUT(PERIOD_COUNT_OUT));

//--- lpd_host_model.sv
// Host model: register writer standing in for the bus master
`timescale 1ns/1ps

module lpd_host_model
    import lpd_pkg::*;
(
    // Clock
    input  wire logic MCLK_IN,
    // Write port towards the driver
    output lpd_wr_t   REG_WR_OUT
);
    // ==========================================================
    // Write tasks
    // ==========================================================
    initial REG_WR_OUT = '0;
    // One-cycle strobe; idle bus shows inverted leftovers, not stale data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge MCLK_IN);
        REG_WR_OUT = '{wr: 1'b1, addr: a, data: d};
        @(negedge MCLK_IN);
        REG_WR_OUT = '{wr: 1'b0, addr: ~a, data: ~d};
    endtask
    // Update trigger after a batch of writes
    task automatic apply;
        wr(LPD_OFS_APPLY, LPD_CMD_TRIGGER);
    endtask
endmodule

//--- led_pwm_channel_driver_tb_top.sv
// Testbench: register-write scenarios for the LED PWM driver
`timescale 1ns/1ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %0h got %0h", nm, e, a); end end

module led_pwm_channel_driver_tb_top;
    import lpd_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic         clk = 1'b0;           // 100 MHz clock
    logic         rst = 1'b1;           // Sync reset
    logic         hw_shutdown_n = 1'b1; // Pin shutdown, low active
    lpd_wr_t      wr_bus;               // Host writes
    logic [17:0]  led;                  // Channel sinks
    logic [107:0] scale;                // Active scale codes
    int           mismatches = 0;
    int           compares = 0;
    int           on;                   // Lit cycles seen
    logic [7:0]   cnt;                  // Shared period counter
    logic [7:0]   cnt0;                 // Counter one cycle earlier
    logic [5:0]   codes [5] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h0a};
    logic [7:0]   gam [5] = '{8'h00, 8'h12, 8'h45, 8'h95, 8'hff};
    always #5 clk = ~clk;
    // Short dividers keep a full period at 256 or 512 clocks
    lpd_led_pwm #(.FAST_DIV(1), .SLOW_DIV(2)) dut (.MCLK_IN(clk), .SRST_IN(rst),
        .REG_WR_IN(wr_bus), .HW_SHUTDOWN_N_IN(hw_shutdown_n),
        .LED_CHANNEL_OUTPUTS_OUT(led), .CURRENT_SCALE_FIELD_OUT(scale),
        .PERIOD_COUNT_OUT(cnt));
    lpd_host_model host (.MCLK_IN(clk), .REG_WR_OUT(wr_bus));
    // ==========================================================
    // Tasks
    // ==========================================================
    // Count lit cycles of one channel
    task automatic meas(input int ch, input int n);
        on = 0;
        repeat (n) begin
            @(negedge clk);
            if (led[ch] === 1'b1) on++;
        end
    endtask
    // Write, settle, then check channel 1 over one period
    task automatic wm(input logic [7:0] a, input logic [7:0] d, input int exp);
        host.wr(a, d);
        repeat (2) @(negedge clk);
        meas(0, 256);
        `CHK("lit", exp, on)
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        `CHK("led", 18'h0, led)
        cnt0 = cnt;
        @(negedge clk);
        `CHK("count", 8'(cnt0 + 8'h01), cnt)
        host.wr(LPD_OFS_SHUTDOWN, 8'h01);
        host.wr(LPD_OFS_DUTY_LO, 8'h80);
        host.wr(LPD_OFS_DUTY_HI, 8'h40);
        host.wr(LPD_OFS_SCALE_LO, 8'hd0); // Top bits ignored
        host.wr(LPD_OFS_SCALE_HI, {2'b00, LPD_SCALE_7});
        host.wr(LPD_OFS_APPLY, 8'h01);    // Nonzero trigger is ignored
        repeat (3) @(negedge clk);
        `CHK("held", 108'h0, scale)
        wm(LPD_OFS_APPLY, 8'h00, 128);
        `CHK("scale1", LPD_SCALE_FULL, scale[5:0])
        `CHK("scale18", LPD_SCALE_7, scale[107:102])
        meas(17, 256);
        `CHK("duty18", 64, on)
        // Four lit scale codes and dark code 0Ah, channel 1 at half duty
        foreach (codes[i]) begin
            host.wr(LPD_OFS_SCALE_LO, {2'b00, codes[i]});
            wm(LPD_OFS_APPLY, 8'h00, codes[i][4] ? 128 : 0);
        end
        // Breathing steps, zero and full scale included
        host.wr(LPD_OFS_SCALE_LO, 8'h10);
        foreach (gam[i]) begin
            host.wr(LPD_OFS_DUTY_LO, gam[i]);
            wm(LPD_OFS_APPLY, 8'h00, int'(gam[i]));
        end
        wm(LPD_OFS_GLOBAL, 8'h01, 0);
        wm(LPD_OFS_GLOBAL, 8'h00, 255);
        wm(LPD_OFS_SHUTDOWN, 8'h00, 0);
        wm(LPD_OFS_SHUTDOWN, 8'h01, 255);
        hw_shutdown_n = 1'b0;
        wm(8'h30, 8'h5a, 0);
        `CHK("hw scale", 108'h0, scale)
        hw_shutdown_n = 1'b1;
        wm(8'h31, 8'h00, 255);
        host.wr(LPD_OFS_FREQ, 8'h01);
        repeat (4) @(negedge clk);
        meas(0, 512);
        `CHK("slow", 510, on)
        host.wr(LPD_OFS_RESTORE, 8'h00);
        repeat (2) @(negedge clk);
        `CHK("restore", 108'h0, scale)
        wm(LPD_OFS_SHUTDOWN, 8'h01, 0);
        conclude();
    end
    // Hang guard, several times the expected run
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
endmodule
